/* File: ppo_pkg.sv */
// Purpose: shared constants for the process PID output stage
// Assumes: percentages are signed 16-bit values in steps of 0.1 %
// Notes: AHB-Lite register map, reset values, timing and state codes
package ppo_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLOCK_MHZ = 100;
	localparam int SAMPLE_PERIOD_US = 1000; // filter and hold timers step once per 1 ms
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * CLOCK_MHZ;
	localparam int TC_UNIT_US = 10000; // filter constant counts 0.01 s
	localparam int HOLD_UNIT_US = 100000; // hold time counts 0.1 s
	localparam int TC_TICKS_PER_UNIT = TC_UNIT_US / SAMPLE_PERIOD_US;
	localparam int HOLD_TICKS_PER_UNIT = HOLD_UNIT_US / SAMPLE_PERIOD_US;
	localparam int PCT_SCALE = 1000; // 100.0 % in 0.1 % steps
	localparam int FRAC_BITS = 16; // fraction bits of the filter accumulator

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_POS_LIMIT = 8'h04;
	localparam logic [7:0] OFS_NEG_LIMIT = 8'h08;
	localparam logic [7:0] OFS_FILTER_TC = 8'h0C;
	localparam logic [7:0] OFS_REWIND_GAIN = 8'h10;
	localparam logic [7:0] OFS_UNWIND_GAIN = 8'h14;
	localparam logic [7:0] OFS_FLOOR = 8'h18;
	localparam logic [7:0] OFS_HOLD_TIME = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_FINAL_CMD = 8'h24;

	// ------------------------------------------------------------
	// control fields and reset values
	// ------------------------------------------------------------
	localparam int CTL_MERGE_BIT = 0; // 0 proportional, 1 fixed
	localparam int CTL_WIND_BIT = 1; // 0 rewind, 1 unwind
	localparam int CTL_HOLD_BIT = 2; // hold command level
	localparam logic [2:0] RST_CONTROL = 3'h0;
	localparam logic signed [15:0] RST_POS_LIMIT = 16'sh03E8; // 100.0 %
	localparam logic signed [15:0] RST_NEG_LIMIT = 16'shFC18; // -100.0 %
	localparam logic [15:0] RST_FILTER_TC = 16'h0064; // 1.00 s
	localparam logic signed [15:0] RST_GAIN = 16'sh0000;
	localparam logic signed [15:0] RST_FLOOR = 16'sh0064; // 10.0 %
	localparam logic [15:0] RST_HOLD_TIME = 16'h0032; // 5.0 s

	// hold sequence states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HOLD_PID = 2'b01,
		ST_COAST = 2'b10
	} ppo_state_t;

endpackage

/* File: ppo_div_if.sv */
// Purpose: request and answer bundle of the serial divider
// Assumes: one clock shared by both ends
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
interface ppo_div_if;
	logic start;
	logic [31:0] dividend;
	logic [16:0] divisor;
	logic busy;
	logic done;
	logic [31:0] quotient;

	modport requester (output start, output dividend, output divisor,
		input busy, input done, input quotient);
	modport server (input start, input dividend, input divisor,
		output busy, output done, output quotient);
endinterface

/* File: ppo_divider.sv */
// Purpose: unsigned restoring divider, one quotient bit per cycle
// Assumes: divisor is never zero
// Notes: answer comes 33 enabled cycles after start
`timescale 1ns/100ps
module ppo_divider
(
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	ppo_div_if.server divBus
);

	logic [17:0] remReg;
	logic [31:0] quoReg;
	logic [31:0] quoNext;
	logic [16:0] dvsReg;
	logic [5:0] cntReg;
	logic busyReg;
	logic doneReg;
	logic [17:0] remShift;
	logic remFits;
	logic [17:0] remNext;

	// one restoring step
	assign remShift = {remReg[16:0], quoReg[31]};
	assign remFits = remShift >= {1'b0, dvsReg};
	assign remNext = remFits ? remShift - {1'b0, dvsReg} : remShift;
	assign quoNext = {quoReg[30:0], remFits};

	// iteration control
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			remReg <= 18'h00000;
			quoReg <= 32'h00000000;
			dvsReg <= 17'h00000;
			cntReg <= 6'h00;
			busyReg <= 1'b0;
			doneReg <= 1'b0;
		end
		else if (clockEnable)
		begin
			doneReg <= busyReg && cntReg == 6'h1F;
			if (divBus.start && !busyReg)
			begin
				remReg <= 18'h00000;
				quoReg <= divBus.dividend;
				dvsReg <= divBus.divisor;
				cntReg <= 6'h00;
				busyReg <= 1'b1;
			end
			else if (busyReg)
			begin
				remReg <= remNext;
				quoReg <= quoNext;
				cntReg <= cntReg + 6'h01;
				busyReg <= cntReg != 6'h1F;
			end
		end
	end

	assign divBus.busy = busyReg;
	assign divBus.done = doneReg;
	assign divBus.quotient = quoReg;

endmodule // ppo_divider

/* File: ppo_output_stage.sv */
// Purpose: limit, filter, scale and merge the process PID output
// Assumes: pidRaw and lineSpeedCmd come from logic on this clock
// Notes: registers on AHB-Lite, zero wait states, always OKAY
// Notes on behaviour
// [RQ1] clamp PID output so it never exceeds the positive limit; a negative limit set above it wins instead
// [RQ2] clamp PID output so it never falls below the negative limit
// [RQ3] first-order low-pass on PID output, time constant in 0.01 s
// [RQ4] scale by rewind gain or unwind gain by wind direction
// [RQ5] gain is percent of max line speed; negative gain inverts correction
// [RQ6] final command never goes below zero, so no reverse drive
// [RQ7] fixed mode: final command is line speed plus PID output
// [RQ8] proportional mode above floor: add PID times line speed over 100
// [RQ9] proportional mode below floor: add PID times floor over 100
// [RQ10] hold command drives the speed reference toward zero
// [RQ11] after hold, PID runs for hold time, then motor coasts
// [RQ12] during hold, zero PID output stops the motor at once
// [RQ13] line speed equal to floor uses the above-floor formula
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module ppo_output_stage
#(
	parameter int SAMPLE_CYCLES = ppo_pkg::SAMPLE_CYCLES
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic signed [15:0] pidRaw,
	input wire logic signed [15:0] lineSpeedCmd,
	output logic signed [15:0] finalSpeedCmd,
	output logic holdActive,
	output logic motorCoast
);

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic [2:0] controlReg;
	logic signed [15:0] posLimitReg, negLimitReg, rewindGainReg, unwindGainReg, floorReg;
	logic [15:0] filterTcReg, holdTimeReg;
	logic wrPendReg;
	logic [7:0] wrAddrReg;
	logic [31:0] hrdataReg;
	logic hreadyoutReg;
	logic signed [15:0] finalReg;
	logic holdActiveReg, coastReg;
	ppo_pkg::ppo_state_t stateReg, stateNext;
	logic signed [31:0] filtAccReg;
	logic signed [15:0] filtPid;
	logic addrPhase;
	logic [31:0] readValue;

	// word offset of a bus address
	function automatic logic [7:0] wordOffset(input logic [31:0] addr);
		wordOffset = {addr[7:2], 2'b00};
	endfunction

	assign addrPhase = hsel && htrans[1] && hready;

	// read mux, unmapped offsets read zero
	always_comb
	begin
		unique case (wordOffset(haddr))
			ppo_pkg::OFS_CONTROL: readValue = {29'h00000000, controlReg};
			ppo_pkg::OFS_POS_LIMIT: readValue = {{16{posLimitReg[15]}}, posLimitReg};
			ppo_pkg::OFS_NEG_LIMIT: readValue = {{16{negLimitReg[15]}}, negLimitReg};
			ppo_pkg::OFS_FILTER_TC: readValue = {16'h0000, filterTcReg};
			ppo_pkg::OFS_REWIND_GAIN: readValue = {{16{rewindGainReg[15]}}, rewindGainReg};
			ppo_pkg::OFS_UNWIND_GAIN: readValue = {{16{unwindGainReg[15]}}, unwindGainReg};
			ppo_pkg::OFS_FLOOR: readValue = {{16{floorReg[15]}}, floorReg};
			ppo_pkg::OFS_HOLD_TIME: readValue = {16'h0000, holdTimeReg};
			ppo_pkg::OFS_STATUS: readValue = {16'h0000, filtPid};
			ppo_pkg::OFS_FINAL_CMD: readValue = {{16{finalReg[15]}}, finalReg};
			default: readValue = 32'h00000000;
		endcase
	end

	// address phase capture and read data
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			wrPendReg <= 1'b0;
			wrAddrReg <= 8'h00;
			hrdataReg <= 32'h00000000;
			hreadyoutReg <= 1'b0;
		end
		else if (clockEnable)
		begin
			hreadyoutReg <= 1'b1;
			wrPendReg <= addrPhase && hwrite;
			wrAddrReg <= wordOffset(haddr);
			if (addrPhase && !hwrite)
				hrdataReg <= readValue;
		end
	end

	// register writes at the end of the data phase
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			controlReg <= ppo_pkg::RST_CONTROL;
			posLimitReg <= ppo_pkg::RST_POS_LIMIT;
			negLimitReg <= ppo_pkg::RST_NEG_LIMIT;
			filterTcReg <= ppo_pkg::RST_FILTER_TC;
			rewindGainReg <= ppo_pkg::RST_GAIN;
			unwindGainReg <= ppo_pkg::RST_GAIN;
			floorReg <= ppo_pkg::RST_FLOOR;
			holdTimeReg <= ppo_pkg::RST_HOLD_TIME;
		end
		else if (clockEnable && wrPendReg)
		begin
			unique case (wrAddrReg)
				ppo_pkg::OFS_CONTROL: controlReg <= hwdata[2:0];
				ppo_pkg::OFS_POS_LIMIT: posLimitReg <= hwdata[15:0];
				ppo_pkg::OFS_NEG_LIMIT: negLimitReg <= hwdata[15:0];
				ppo_pkg::OFS_FILTER_TC: filterTcReg <= hwdata[15:0];
				ppo_pkg::OFS_REWIND_GAIN: rewindGainReg <= hwdata[15:0];
				ppo_pkg::OFS_UNWIND_GAIN: unwindGainReg <= hwdata[15:0];
				ppo_pkg::OFS_FLOOR: floorReg <= hwdata[15:0];
				ppo_pkg::OFS_HOLD_TIME: holdTimeReg <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// limiter and low-pass filter
	// ------------------------------------------------------------
	logic signed [15:0] upClamp, clampedPid;
	logic [16:0] sampleCntReg;
	logic sampleTick;
	logic signed [31:0] targetAcc, diffAcc;
	logic diffNegReg, startReg;
	logic [31:0] diffMagReg;
	logic [16:0] tcTicks;
	logic signed [31:0] stepAcc;
	ppo_div_if divBus();

	// positive limit first, negative limit has the last word
	assign upClamp = (pidRaw > posLimitReg) ? posLimitReg : pidRaw; // see RQ1
	assign clampedPid = (upClamp < negLimitReg) ? negLimitReg : upClamp; // see RQ2

	assign sampleTick = sampleCntReg == 17'(SAMPLE_CYCLES - 1);
	assign targetAcc = 32'(clampedPid) <<< ppo_pkg::FRAC_BITS;
	assign diffAcc = targetAcc - filtAccReg;
	assign tcTicks = 17'(filterTcReg * ppo_pkg::TC_TICKS_PER_UNIT + 1); // see RQ3
	assign stepAcc = diffNegReg ? -$signed(divBus.quotient) : $signed(divBus.quotient);
	assign filtPid = filtAccReg[ppo_pkg::FRAC_BITS +: 16];
	assign divBus.start = startReg;
	assign divBus.dividend = diffMagReg;
	assign divBus.divisor = tcTicks;

	// sample timer and filter step: y += (x - y) / (tau / Ts + 1)
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sampleCntReg <= 17'h00000;
			startReg <= 1'b0;
			diffNegReg <= 1'b0;
			diffMagReg <= 32'h00000000;
			filtAccReg <= 32'sh00000000;
		end
		else if (clockEnable)
		begin
			sampleCntReg <= sampleTick ? 17'h00000 : sampleCntReg + 17'h00001;
			startReg <= sampleTick && !divBus.busy;
			if (sampleTick)
			begin
				diffNegReg <= diffAcc < 0;
				diffMagReg <= (diffAcc < 0) ? 32'(-diffAcc) : 32'(diffAcc);
			end
			if (divBus.done)
				filtAccReg <= filtAccReg + stepAcc; // see RQ3
		end
	end

	ppo_divider i_ppo_divider
	(
		.clock(clock),
		.reset(reset),
		.clockEnable(clockEnable),
		.divBus(divBus)
	);

	// ------------------------------------------------------------
	// gain, merge and hold sequence
	// ------------------------------------------------------------
	logic signed [15:0] selGain, scaledPid, lineEff, factor, addPid;
	logic signed [31:0] gainProd, mergeProd;
	logic signed [17:0] sumCmd;
	logic [16:0] holdCntReg;
	logic [16:0] holdLimit;
	logic holdCmd, holdExpired;
	logic signed [15:0] finalNext;

	assign selGain = controlReg[ppo_pkg::CTL_WIND_BIT] ? unwindGainReg : rewindGainReg; // see RQ4
	assign gainProd = filtPid * selGain; // see RQ5
	assign scaledPid = 16'(gainProd / ppo_pkg::PCT_SCALE); // see RQ5
	assign lineEff = (stateReg == ppo_pkg::ST_RUN) ? lineSpeedCmd : 16'sh0000; // see RQ10
	assign factor = (lineEff >= floorReg) ? lineEff : floorReg; // see RQ8 see RQ9 see RQ13
	assign mergeProd = scaledPid * factor;
	assign addPid = controlReg[ppo_pkg::CTL_MERGE_BIT] ? scaledPid
		: 16'(mergeProd / ppo_pkg::PCT_SCALE); // see RQ7 see RQ8
	assign sumCmd = 18'(lineEff) + 18'(addPid);
	assign finalNext = (stateReg == ppo_pkg::ST_COAST || sumCmd < 0) ? 16'sh0000
		: (sumCmd > 18'sh07FFF) ? 16'sh7FFF : 16'(sumCmd); // see RQ6

	assign holdCmd = controlReg[ppo_pkg::CTL_HOLD_BIT];
	assign holdLimit = 17'(holdTimeReg * ppo_pkg::HOLD_TICKS_PER_UNIT);
	assign holdExpired = holdCntReg >= holdLimit;

	// hold sequence next state
	always_comb
	begin
		stateNext = stateReg;
		unique case (stateReg)
			ppo_pkg::ST_RUN:
				if (holdCmd)
					stateNext = ppo_pkg::ST_HOLD_PID; // see RQ10
			ppo_pkg::ST_HOLD_PID:
				if (!holdCmd)
					stateNext = ppo_pkg::ST_RUN;
				else if (filtPid == 16'sh0000 || holdExpired)
					stateNext = ppo_pkg::ST_COAST; // see RQ11 see RQ12
			ppo_pkg::ST_COAST:
				if (!holdCmd)
					stateNext = ppo_pkg::ST_RUN;
			default: stateNext = ppo_pkg::ST_RUN;
		endcase
	end

	// state, hold timer and outputs
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			stateReg <= ppo_pkg::ST_RUN;
			holdCntReg <= 17'h00000;
			finalReg <= 16'sh0000;
			holdActiveReg <= 1'b0;
			coastReg <= 1'b0;
		end
		else if (clockEnable)
		begin
			stateReg <= stateNext;
			if (stateReg != ppo_pkg::ST_HOLD_PID)
				holdCntReg <= 17'h00000;
			else if (sampleTick && !holdExpired)
				holdCntReg <= holdCntReg + 17'h00001; // see RQ11
			finalReg <= finalNext;
			holdActiveReg <= stateNext != ppo_pkg::ST_RUN;
			coastReg <= stateNext == ppo_pkg::ST_COAST;
		end
	end

	assign hrdata = hrdataReg;
	assign hreadyout = hreadyoutReg;
	assign hresp = 1'b0;
	assign finalSpeedCmd = finalReg;
	assign holdActive = holdActiveReg;
	assign motorCoast = coastReg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_pos_limit_clamp: assert property (posLimitReg >= negLimitReg |-> clampedPid <= posLimitReg) // see RQ1
		else $error("clamped PID above positive limit");
	a_neg_limit_clamp: assert property (clampedPid >= negLimitReg) // see RQ2
		else $error("clamped PID below negative limit");
	// divisor is latched one cycle after the tick, 33 cycles before done
	a_filter_passthrough: assert property (clockEnable && divBus.done // see RQ3
		&& filterTcReg == 16'h0000 && $past(filterTcReg, 33) == 16'h0000
		|=> filtAccReg == $past(targetAcc, 35))
		else $error("zero time constant filter did not reach its input");
	a_gain_select_unwind: assert property (controlReg[ppo_pkg::CTL_WIND_BIT] // see RQ4
		&& unwindGainReg == 16'sh0000 |-> scaledPid == 16'sh0000)
		else $error("unwind gain not selected");
	a_gain_sign_invert: assert property (filtPid > 0 && selGain < 0 |-> scaledPid <= 0) // see RQ5
		else $error("negative gain did not invert the correction");
	a_no_reverse_drive: assert property (finalSpeedCmd >= 0) // see RQ6
		else $error("final command went negative");
	a_fixed_merge_sum: assert property (clockEnable // see RQ7
		&& controlReg[ppo_pkg::CTL_MERGE_BIT]
		&& stateReg == ppo_pkg::ST_RUN && sumCmd >= 0 && sumCmd <= 18'sh07FFF
		|=> finalSpeedCmd == $past(lineSpeedCmd) + $past(scaledPid))
		else $error("fixed mode sum wrong");
	a_floor_factor_pick: assert property (lineEff >= floorReg |-> factor == lineEff) // see RQ8 see RQ13
		else $error("above-floor factor wrong");
	a_below_floor_pick: assert property (lineEff < floorReg |-> factor == floorReg) // see RQ9
		else $error("below-floor factor wrong");
	a_hold_zero_line: assert property (stateReg != ppo_pkg::ST_RUN |-> lineEff == 16'sh0000) // see RQ10
		else $error("line speed used during hold");
	a_hold_time_coast: assert property (clockEnable && holdExpired // see RQ11
		&& stateReg == ppo_pkg::ST_HOLD_PID && holdCmd |=> motorCoast)
		else $error("hold time elapsed without coasting");
	a_hold_zero_stop: assert property (clockEnable && filtPid == 16'sh0000 // see RQ12
		&& stateReg == ppo_pkg::ST_HOLD_PID && holdCmd
		|=> stateReg == ppo_pkg::ST_COAST ##0 finalSpeedCmd == 0)
		else $error("zero PID output did not stop the motor");

	// hold sequence entry, exit and output flags, and rewind gain select
	a_hold_entry_step: assert property (clockEnable && holdCmd // see RQ10
		&& stateReg == ppo_pkg::ST_RUN |=> stateReg == ppo_pkg::ST_HOLD_PID)
		else $error("hold command did not start the hold sequence");
	a_hold_release_run: assert property (clockEnable && !holdCmd // see RQ11
		&& stateReg != ppo_pkg::ST_RUN |=> stateReg == ppo_pkg::ST_RUN)
		else $error("hold release did not return to run");
	a_coast_cmd_zero: assert property (clockEnable // see RQ11
		&& stateReg == ppo_pkg::ST_COAST |=> finalSpeedCmd == 16'sh0000)
		else $error("speed command not zero while coasting");
	a_hold_flag_match: assert property (holdActive == (stateReg != ppo_pkg::ST_RUN)) // see RQ10
		else $error("hold flag does not follow the hold sequence");
	a_coast_flag_match: assert property (motorCoast == (stateReg == ppo_pkg::ST_COAST)) // see RQ11
		else $error("coast flag does not follow the hold sequence");
	a_gain_select_rewind: assert property (!controlReg[ppo_pkg::CTL_WIND_BIT] // see RQ4
		&& rewindGainReg == 16'sh0000 |-> scaledPid == 16'sh0000)
		else $error("rewind gain not selected");

	// cover points for the main scenarios

	c_fixed_run: cover property (controlReg[ppo_pkg::CTL_MERGE_BIT] && finalSpeedCmd > 0);
	c_below_floor: cover property (!controlReg[ppo_pkg::CTL_MERGE_BIT] && lineEff < floorReg
		&& stateReg == ppo_pkg::ST_RUN);
	c_hold_timeout: cover property (stateReg == ppo_pkg::ST_HOLD_PID && holdExpired ##1 motorCoast);
	c_hold_release: cover property (stateReg == ppo_pkg::ST_COAST ##1 stateReg == ppo_pkg::ST_RUN);
	c_zero_stop: cover property (stateReg == ppo_pkg::ST_HOLD_PID && filtPid == 16'sh0000
		##1 stateReg == ppo_pkg::ST_COAST);

endmodule // ppo_output_stage

/* File: ppo_speed_loop_model.sv */
// Purpose: behavioural speed loop fed by the final line speed command
// Assumes: command in 0.1 % steps, same clock as the output stage
// Notes: slowMode ramps one step a cycle; coast lets the speed run down by friction
`timescale 1ns/100ps
module ppo_speed_loop_model
(
	input wire logic clock,
	input wire logic reset,
	input wire logic slowMode,
	input wire logic signed [15:0] speedCmd,
	input wire logic coast,
	output logic signed [15:0] motorSpeed
);
	// follow the command, or decay toward standstill while released
	always_ff @(posedge clock)
	begin
		if (reset || (coast && motorSpeed == 16'sh0000))
			motorSpeed <= 16'sh0000;
		else if (coast)
			motorSpeed <= motorSpeed - ((motorSpeed > 16'sh0000) ? 16'sh0001 : -16'sh0001);
		else if (!slowMode || speedCmd == motorSpeed)
			motorSpeed <= speedCmd;
		else
			motorSpeed <= motorSpeed + ((speedCmd > motorSpeed) ? 16'sh0001 : -16'sh0001);
	end
endmodule // ppo_speed_loop_model

/* File: tb_process_pid_output_stage.sv */
// Purpose: self-checking bench for the process PID output stage
// Assumes: sample period shortened to 50 cycles
// Notes: 150-cycle waits let the filter and divider settle
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_process_pid_output_stage;
	localparam int SC = 50;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic signed [15:0] pidRaw = 16'sh0000;
	logic signed [15:0] lineSpeedCmd = 16'sh0000;
	logic signed [15:0] finalSpeedCmd;
	logic holdActive;
	logic motorCoast;
	logic slowMode = 1'b0;
	logic signed [15:0] motorSpeed;
	logic [31:0] rd;
	int failures = 0;
	int tests_run = 0;

	// one slave, so its hreadyout is the bus hready
	ppo_output_stage #(.SAMPLE_CYCLES(SC)) i_ppo_output_stage (.clock(clock), .reset(reset),
		.clockEnable(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pidRaw(pidRaw), .lineSpeedCmd(lineSpeedCmd),
		.finalSpeedCmd(finalSpeedCmd), .holdActive(holdActive), .motorCoast(motorCoast));
	ppo_speed_loop_model i_ppo_speed_loop_model (.clock(clock), .reset(reset),
		.slowMode(slowMode), .speedCmd(finalSpeedCmd), .coast(motorCoast),
		.motorSpeed(motorSpeed));

	// 100 MHz clock
	always #5 clock = ~clock;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic settle();
		cyc(150);
	endtask

	// single AHB-Lite word transfer; read data lands in rd
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		`CHK(rd[15:0], e)
	endtask

	task automatic lineChk(input logic signed [15:0] line, input logic signed [15:0] e);
		lineSpeedCmd <= line;
		settle();
		`CHK(finalSpeedCmd, e)
	endtask

	task automatic conclude();
		$display("counts: run=%0d mismatches=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic testResetMap();
		logic [7:0] ofs [8];
		logic [15:0] exp [8];
		ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
		exp = '{16'h0000, 16'h03E8, 16'hFC18, 16'h0064, 16'h0000, 16'h0000, 16'h0064, 16'h0032};
		foreach (ofs[i]) rdChk(ofs[i], exp[i]);
		xfer(1'b1, 8'h20, 32'h0000_1234);
		rdChk(8'h20, 16'h0000);
		xfer(1'b0, 8'h28, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
		`CHK(hresp, 1'b0)
		$display("done: reset values and map");
	endtask

	task automatic testClamp();
		xfer(1'b1, 8'h0C, 32'h0000_0000); // filter passes straight through
		pidRaw <= 16'sh07D0;
		settle();
		rdChk(8'h20, 16'h03E8);
		pidRaw <= 16'shF830;
		settle();
		rdChk(8'h20, 16'hFC18);
		xfer(1'b1, 8'h04, 32'h0000_01F4);
		pidRaw <= 16'sh02BC;
		settle();
		rdChk(8'h20, 16'h01F4);
		xfer(1'b1, 8'h04, 32'h0000_03E8);
		$display("done: output limits");
	endtask

	task automatic testMerge();
		pidRaw <= 16'sh03E8;
		xfer(1'b1, 8'h10, 32'h0000_0064); // rewind gain 10.0 %
		xfer(1'b1, 8'h14, 32'hFFFF_FF9C); // unwind gain -10.0 %
		xfer(1'b1, 8'h00, 32'h0000_0001); // fixed, rewind
		lineChk(16'sh01F4, 16'sh0258);
		xfer(1'b1, 8'h00, 32'h0000_0003); // fixed, unwind
		lineChk(16'sh01F4, 16'sh0190);
		lineChk(16'sh0000, 16'sh0000);
		`CHK(motorSpeed, 16'sh0000)
		xfer(1'b1, 8'h00, 32'h0000_0000); // proportional, rewind
		lineChk(16'sh01F4, 16'sh0226);
		lineChk(16'sh0032, 16'sh003C);
		lineChk(16'sh0064, 16'sh006E);
		xfer(1'b0, 8'h24, 32'h0000_0000);
		`CHK(rd[15:0], 16'h006E)
		$display("done: gain and merge");
	endtask

	task automatic testFilter();
		pidRaw <= 16'sh0000;
		settle();
		xfer(1'b1, 8'h0C, 32'h0000_0001); // 0.01 s constant
		pidRaw <= 16'sh044C; // above the positive limit, so the filter aims at 100.0 %
		cyc(90);
		xfer(1'b0, 8'h20, 32'h0000_0000);
		`CHK($signed(rd[15:0]) > 16'sh0000 && $signed(rd[15:0]) < 16'sh03E8, 1'b1)
		cyc(6000);
		xfer(1'b0, 8'h20, 32'h0000_0000);
		`CHK($signed(rd[15:0]) >= 16'sh03E7 && $signed(rd[15:0]) <= 16'sh03E8, 1'b1)
		xfer(1'b1, 8'h0C, 32'h0000_0000);
		$display("done: output filter");
	endtask

	task automatic testHold();
		pidRaw <= 16'sh03E8;
		lineSpeedCmd <= 16'sh01F4;
		slowMode <= 1'b1;
		xfer(1'b1, 8'h1C, 32'h0000_0001); // 0.1 s, 100 ticks
		xfer(1'b1, 8'h00, 32'h0000_0005); // fixed mode, hold
		settle();
		`CHK({holdActive, motorCoast}, 2'b10)
		`CHK(finalSpeedCmd, 16'sh0064)
		cyc(4550);
		`CHK(motorCoast, 1'b0)
		cyc(600);
		`CHK({motorCoast, finalSpeedCmd}, {1'b1, 16'sh0000})
		xfer(1'b1, 8'h00, 32'h0000_0001);
		cyc(3);
		`CHK(holdActive, 1'b0)
		pidRaw <= 16'sh0000;
		settle();
		xfer(1'b1, 8'h00, 32'h0000_0005);
		cyc(3);
		`CHK(motorCoast, 1'b1)
		xfer(1'b1, 8'h00, 32'h0000_0000);
		$display("done: hold sequence");
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		cyc(5);
		reset <= 1'b0;
		for (int i = 0; i < 20 && hreadyout !== 1'b1; i++) cyc(1);
		testResetMap();
		testClamp();
		testMerge();
		testFilter();
		testHold();
		conclude();
	end

	// cut a hang short well beyond the expected 13100 cycles
	initial
	begin
		cyc(30000);
		failures++;
		conclude();
	end
endmodule // tb_process_pid_output_stage
